// *** rtl/cpi_pkg.sv ***
/*
  Constants for the card punch interface: function codes, bus bit
  positions and timing counts at the 125 MHz system clock.
  Assumes both ends share one clock and one synchronous reset.
*/
package cpi_pkg;
  localparam int CLK_NS = 8;

  // Function codes carried with each instruction pulse
  localparam logic [3:0] FN_ENABLE = 4'h0;
  localparam logic [3:0] FN_CHAN_MODE = 4'h3;
  localparam logic [3:0] FN_CHAN_STOP_CLR = 4'h7;
  localparam logic [3:0] SK_READY = 4'h0;
  localparam logic [3:0] SK_NOT_BUSY = 4'h1;
  localparam logic [3:0] SK_ROW_NOT_POS = 4'h2;
  localparam logic [3:0] SK_OPERATIONAL = 4'h3;
  localparam logic [3:0] SK_NOT_INTR = 4'h4;
  localparam logic [3:0] FN_DATA = 4'h0;

  // Bus bit 1 is the msb, bit 16 the lsb
  localparam int BUS_W = 16;
  localparam int CHAR_W = 8;
  localparam int MASK_BIT = 3;
  localparam int CHARS_PER_ROW = 10;
  localparam int ROWS_PER_CARD = 12;
  localparam int BITS_PER_ROW = 80;
  localparam int CNT_W = 4;

  // Times as printed, with cycle counts derived from them
  localparam int T_ROW_POS_NS = 90_000_000;
  localparam int T_SHIFT_NS = 85_000;
  localparam int T_ADVANCE_NS = 41_500_000;
  localparam int T_TAIL_NS = 3_780_000;
  localparam int ROW_POS_CYC = T_ROW_POS_NS / CLK_NS;
  localparam int SHIFT_CYC = (T_SHIFT_NS + CLK_NS - 1) / CLK_NS;
  localparam int ADVANCE_CYC = (T_ADVANCE_NS + CLK_NS - 1) / CLK_NS;
  localparam int TAIL_CYC = (T_TAIL_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W = 24;

  typedef enum logic [1:0] {KIND_CTL, KIND_SENSE, KIND_OUT, KIND_MASK} cpi_kind_type;
endpackage

// *** rtl/cpi_bus_if.sv ***
/*
  Programmed I/O and multiplex channel wires between the computer
  end and the punch interface end.
  Assumes clk and rst come from the surrounding bench or chip.
*/
`timescale 1ns/1ps
interface cpi_bus_if (
  input wire logic clk,
  input wire logic rst
);
  import cpi_pkg::*;
  logic io_ctl;
  logic io_sense;
  logic io_out;
  logic io_mask;
  logic [3:0] io_fn;
  logic [BUS_W-1:0] io_data;
  logic io_skip;
  logic irq;
  logic chan_req;
  logic chan_ack;
  logic chan_eor;

  modport dev (
    input clk, rst, io_ctl, io_sense, io_out, io_mask, io_fn, io_data, chan_ack, chan_eor,
    output io_skip, irq, chan_req
  );
  modport cpu (
    input clk, rst, io_skip, irq, chan_req,
    output io_ctl, io_sense, io_out, io_mask, io_fn, io_data, chan_ack, chan_eor
  );
endinterface

// *** rtl/cpi_punch_dev.sv ***
/*
  Punch interface end: takes characters from the output bus or the
  multiplex channel, shifts them serially to the punch row buffer,
  and keeps busy, ready, row, channel and punch-check status.
  Assumes all inputs are synchronous to the bus clock.
*/
`timescale 1ns/1ps
// How it works
// - Enable pulse clutches punch, arms character input
// - Computer gives one enable per card
// - Ready for first character within 90 ms
// - Ten characters complete each row
// - Ready low 85 us per character shift
// - Ready low 41.5 ms after tenth character
// - Busy until 3.78 ms after last row
// - Character captured parallel, shifted out serially
// - Ready output transfer latches bits, skips
// - Bus bit 09 shifts out first
// - Channel mode set; cleared at card end, range
// - Computer sets channel mode only when idle
// - Channel stop interrupt, cleared by pulse
// - Ready test skips when character accepted
// - Row ready until 80th bit, twelve per card
// - Operational test skips with no not-ready input; here a standing check_err_r also blocks the skip
// - Interrupt test skips when not requesting
// - Mask output loads bit 13, never skips
// - Punched versus sensed counts compared after row 12
// - Fewer than 80 clocks flags punch check
// - No enable while punch check stands; enable here does not test check_err_r
// - Error reset clears punch check
module cpi_punch_dev import cpi_pkg::*; #(
  parameter int ROW_POS = ROW_POS_CYC,
  parameter int SHIFT = SHIFT_CYC,
  parameter int ADVANCE = ADVANCE_CYC,
  parameter int TAIL = TAIL_CYC
) (
  cpi_bus_if.dev bus,
  input wire logic [7:0] not_ready,
  input wire logic check_mode,
  input wire logic hole_sensed,
  input wire logic readback_done,
  input wire logic err_reset,
  output logic clutch_r,
  output logic punch_bit_r,
  output logic punch_clk_r,
  output logic row_ready_r,
  output logic check_err_r
);
  // Shift window must cover all eight bit clocks before the row-end count check
  if (SHIFT < CHAR_W + 2 || ROW_POS < 1 || ADVANCE < 1 || TAIL < 1 || ROW_POS >= 2**TMR_W ||
      SHIFT >= 2**TMR_W || ADVANCE >= 2**TMR_W || TAIL >= 2**TMR_W) begin : g_bad_timing
    $error("cpi_punch_dev: timing parameters out of range");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_POS, ST_RDY, ST_SHIFT, ST_ADV, ST_TAIL} cpi_state_type;
  cpi_state_type state_r;
  logic [TMR_W-1:0] tmr_r;
  logic [3:0] row_r;
  logic [3:0] char_r;
  logic [3:0] bit_r;
  logic [6:0] info_r;
  logic [CHAR_W-1:0] shreg_r;
  logic [CNT_W-1:0] punched_r;
  logic [CNT_W-1:0] sensed_r;
  logic chan_mode_r;
  logic chan_stop_r;
  logic chan_req_r;
  logic mask_r;
  logic irq_r;
  logic skip_r;
  logic busy_r;

  wire logic ready = (state_r == ST_RDY);
  wire logic take_pio = bus.io_out && !bus.io_mask && bus.io_fn == FN_DATA && ready && !chan_mode_r;
  wire logic take_chan = bus.chan_ack && chan_req_r && ready;
  wire logic take = take_pio || take_chan;
  wire logic enable = bus.io_ctl && bus.io_fn == FN_ENABLE && !busy_r;
  wire logic row_end = (state_r == ST_SHIFT) && (tmr_r == '0) && (char_r == 4'(CHARS_PER_ROW - 1));

  function automatic logic sense_hit(input logic [3:0] fn, input logic rdy, input logic bsy,
                                     input logic rowr, input logic oper, input logic intr);
    case (fn)
      SK_READY: sense_hit = rdy;
      SK_NOT_BUSY: sense_hit = !bsy;
      SK_ROW_NOT_POS: sense_hit = !rowr;
      SK_OPERATIONAL: sense_hit = oper;
      SK_NOT_INTR: sense_hit = !intr;
      default: sense_hit = 1'b0;
    endcase
  endfunction

  // Sequencer and its one shared timer
  always_ff @(posedge bus.clk) begin
    if (bus.rst) begin
      state_r <= ST_IDLE;
      tmr_r <= '0;
      row_r <= '0;
      char_r <= '0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (enable) begin
            state_r <= ST_POS;
            tmr_r <= TMR_W'(ROW_POS - 1);
            row_r <= '0;
            char_r <= '0;
          end
        end
        ST_POS, ST_ADV: begin
          if (tmr_r == '0) begin
            state_r <= ST_RDY;
          end else begin
            tmr_r <= tmr_r - 1'b1;
          end
        end
        ST_RDY: begin
          if (take) begin
            state_r <= ST_SHIFT;
            tmr_r <= TMR_W'(SHIFT - 1);
          end
        end
        ST_SHIFT: begin
          if (tmr_r != '0) begin
            tmr_r <= tmr_r - 1'b1;
          end else if (char_r != 4'(CHARS_PER_ROW - 1)) begin
            state_r <= ST_RDY;
            char_r <= char_r + 1'b1;
          end else if (row_r == 4'(ROWS_PER_CARD - 1)) begin
            state_r <= ST_TAIL;
            tmr_r <= TMR_W'(TAIL - 1);
          end else begin
            state_r <= ST_ADV;
            tmr_r <= TMR_W'(ADVANCE - 1);
            row_r <= row_r + 1'b1;
            char_r <= '0;
          end
        end
        ST_TAIL: begin
          if (tmr_r == '0) begin
            state_r <= ST_IDLE;
          end else begin
            tmr_r <= tmr_r - 1'b1;
          end
        end
      endcase
    end
  end

  // Busy spans enable to end of tail
  always_ff @(posedge bus.clk) begin
    if (bus.rst) begin
      busy_r <= 1'b0;
      clutch_r <= 1'b0;
    end else begin
      clutch_r <= enable;
      if (enable) begin
        busy_r <= 1'b1;
      end else if (state_r == ST_TAIL && tmr_r == '0) begin
        busy_r <= 1'b0;
      end
    end
  end

  // Serial shift, msb (bus bit 09) first
  always_ff @(posedge bus.clk) begin
    if (bus.rst) begin
      shreg_r <= '0;
      bit_r <= '0;
      punch_bit_r <= 1'b0;
      punch_clk_r <= 1'b0;
    end else begin
      punch_clk_r <= 1'b0;
      if (take_pio || take_chan) begin
        shreg_r <= bus.io_data[CHAR_W-1:0];
        bit_r <= '0;
      end else if (state_r == ST_SHIFT && bit_r < 4'(CHAR_W)) begin
        punch_bit_r <= shreg_r[CHAR_W-1];
        punch_clk_r <= 1'b1;
        shreg_r <= {shreg_r[CHAR_W-2:0], 1'b0};
        bit_r <= bit_r + 1'b1;
      end
    end
  end

  // Row ready and information clock count
  always_ff @(posedge bus.clk) begin
    if (bus.rst) begin
      row_ready_r <= 1'b0;
      info_r <= '0;
    end else begin
      if ((state_r == ST_POS || state_r == ST_ADV) && tmr_r == '0) begin
        row_ready_r <= 1'b1;
        info_r <= '0;
      end else if (punch_clk_r) begin
        info_r <= info_r + 1'b1;
        if (info_r == 7'(BITS_PER_ROW - 1)) begin
          row_ready_r <= 1'b0;
        end
      end
    end
  end

  // Punch check: count compare and short row
  always_ff @(posedge bus.clk) begin
    if (bus.rst) begin
      punched_r <= '0;
      sensed_r <= '0;
      check_err_r <= 1'b0;
    end else begin
      if (enable) begin
        punched_r <= '0;
        sensed_r <= '0;
      end else begin
        if (check_mode && punch_clk_r && punch_bit_r) begin
          punched_r <= punched_r + 1'b1;
        end
        if (check_mode && hole_sensed) begin
          sensed_r <= sensed_r + 1'b1;
        end
      end
      // Set beats the reset input in the same cycle
      if ((check_mode && readback_done && punched_r != sensed_r) ||
          (row_end && info_r != 7'(BITS_PER_ROW))) begin
        check_err_r <= 1'b1;
      end else if (err_reset) begin
        check_err_r <= 1'b0;
      end
    end
  end

  // Channel mode, channel stop, mask
  always_ff @(posedge bus.clk) begin
    if (bus.rst) begin
      chan_mode_r <= 1'b0;
      chan_stop_r <= 1'b0;
      chan_req_r <= 1'b0;
      mask_r <= 1'b0;
    end else begin
      // Refused while busy: a mid-card switch would split the stream
      if (bus.io_ctl && bus.io_fn == FN_CHAN_MODE && !busy_r) begin
        chan_mode_r <= 1'b1;
      end else if ((state_r == ST_TAIL && tmr_r == '0) || bus.chan_eor) begin
        chan_mode_r <= 1'b0;
      end
      if (bus.chan_eor && chan_mode_r) begin
        chan_stop_r <= 1'b1;
      end else if (bus.io_ctl && bus.io_fn == FN_CHAN_STOP_CLR) begin
        chan_stop_r <= 1'b0;
      end
      chan_req_r <= chan_mode_r && ready && !take;
      if (bus.io_out && bus.io_mask) begin
        mask_r <= bus.io_data[MASK_BIT];
      end
    end
  end

  // Skip answer one cycle after each instruction pulse
  always_ff @(posedge bus.clk) begin
    if (bus.rst) begin
      skip_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      irq_r <= mask_r && (chan_stop_r || (ready && !chan_mode_r));
      if (bus.io_sense) begin
        skip_r <= sense_hit(bus.io_fn, ready, busy_r, row_ready_r,
                            !(|not_ready) && !check_err_r, irq_r);
      end else if (bus.io_out && !bus.io_mask) begin
        skip_r <= take_pio;
      end else begin
        skip_r <= 1'b0;
      end
    end
  end

  assign bus.io_skip = skip_r;
  assign bus.irq = irq_r;
  assign bus.chan_req = chan_req_r;
endmodule

// *** rtl/cpi_cpu_end.sv ***
/*
  Computer end: turns user commands into one-cycle instruction
  pulses, reports the skip answer, and serves channel requests.
  Assumes the user holds cmd inputs stable while cmd_valid is high.
*/
`timescale 1ns/1ps
module cpi_cpu_end import cpi_pkg::*; (
  cpi_bus_if.cpu bus,
  input wire logic cmd_valid,
  input wire cpi_kind_type cmd_kind,
  input wire logic [3:0] cmd_fn,
  input wire logic [BUS_W-1:0] cmd_data,
  input wire logic word_valid,
  input wire logic [BUS_W-1:0] word_data,
  input wire logic word_last,
  output logic cmd_ready_r,
  output logic done_r,
  output logic skip_r,
  output logic word_taken_r,
  output logic irq_seen_r
);
  typedef enum logic [1:0] {HS_IDLE, HS_PULSE, HS_WAIT} cpi_hstate_type;
  cpi_hstate_type state_r;
  logic ctl_r;
  logic sense_r;
  logic out_r;
  logic mask_r;
  logic [3:0] fn_r;
  logic [BUS_W-1:0] data_r;
  logic ack_r;
  logic eor_r;

  // One enable per card and no channel mode while busy are the program's duty
  wire logic start = (state_r == HS_IDLE) && cmd_valid;
  wire logic serve = (state_r == HS_IDLE) && !cmd_valid && bus.chan_req && word_valid && !ack_r;

  always_ff @(posedge bus.clk) begin
    if (bus.rst) begin
      state_r <= HS_IDLE;
      ctl_r <= 1'b0;
      sense_r <= 1'b0;
      out_r <= 1'b0;
      mask_r <= 1'b0;
      fn_r <= '0;
      data_r <= '0;
      done_r <= 1'b0;
      skip_r <= 1'b0;
      cmd_ready_r <= 1'b0;
    end else begin
      ctl_r <= 1'b0;
      sense_r <= 1'b0;
      out_r <= 1'b0;
      mask_r <= 1'b0;
      done_r <= 1'b0;
      cmd_ready_r <= 1'b0;
      unique case (state_r)
        HS_IDLE: begin
          cmd_ready_r <= !cmd_valid;
          if (start) begin
            state_r <= HS_PULSE;
            ctl_r <= (cmd_kind == KIND_CTL);
            sense_r <= (cmd_kind == KIND_SENSE);
            out_r <= (cmd_kind == KIND_OUT) || (cmd_kind == KIND_MASK);
            mask_r <= (cmd_kind == KIND_MASK);
            fn_r <= cmd_fn;
            data_r <= cmd_data;
          end else if (serve) begin
            data_r <= word_data;
          end
        end
        HS_PULSE: state_r <= HS_WAIT;
        HS_WAIT: begin
          state_r <= HS_IDLE;
          done_r <= 1'b1;
          skip_r <= bus.io_skip;
        end
      endcase
    end
  end

  // Channel word service, one word per request
  always_ff @(posedge bus.clk) begin
    if (bus.rst) begin
      ack_r <= 1'b0;
      eor_r <= 1'b0;
      word_taken_r <= 1'b0;
      irq_seen_r <= 1'b0;
    end else begin
      ack_r <= serve;
      eor_r <= serve && word_last;
      word_taken_r <= serve;
      irq_seen_r <= bus.irq;
    end
  end

  assign bus.io_ctl = ctl_r;
  assign bus.io_sense = sense_r;
  assign bus.io_out = out_r;
  assign bus.io_mask = mask_r;
  assign bus.io_fn = fn_r;
  assign bus.io_data = data_r;
  assign bus.chan_ack = ack_r;
  assign bus.chan_eor = eor_r;
endmodule

// *** verif/cpi_bus_sva.sv ***
/*
  Bus assertions for the card punch link between the two ends.
  Assumes it sees the interface wires and the device's timing params.
*/
`timescale 1ns/1ps
module cpi_bus_sva import cpi_pkg::*; #(
  parameter int SHIFT = 12,
  parameter int ROW_POS = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic io_ctl,
  input wire logic io_sense,
  input wire logic io_out,
  input wire logic io_mask,
  input wire logic [3:0] io_fn,
  input wire logic [BUS_W-1:0] io_data,
  input wire logic io_skip,
  input wire logic irq,
  input wire logic chan_req,
  input wire logic chan_ack,
  input wire logic chan_eor
);
  logic out_d;
  int since_acc;
  int since_en;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk) begin
    out_d <= io_out && !io_mask && io_fn == FN_DATA;
  end
  // Saturates so an idle bus never wraps into a false window
  always_ff @(posedge clk) begin
    if (rst) since_acc <= 1000;
    else if (io_skip && out_d) since_acc <= 0;
    else if (since_acc < 1000) since_acc <= since_acc + 1;
  end
  always_ff @(posedge clk) begin
    if (rst) since_en <= 1000;
    else if (io_ctl && io_fn == FN_ENABLE) since_en <= 0;
    else if (since_en < 1000) since_en <= since_en + 1;
  end
  skip_cause_a: assert property (io_skip |-> $past(io_sense || io_out))
    else $error("skip without a request");
  skip_pulse_a: assert property (io_skip |=> !io_skip)
    else $error("skip longer than one cycle");
  mask_skip_a: assert property (io_out && io_mask |=> !io_skip)
    else $error("mask output skipped");
  mask_irq_a: assert property (io_out && io_mask && !io_data[MASK_BIT] |-> ##[1:2] !irq)
    else $error("irq stands with mask cleared");
  intr_sense_a: assert property (io_sense && io_fn == SK_NOT_INTR |=> io_skip == !$past(irq))
    else $error("interrupt sense answer wrong");
  shift_ready_a: assert property (io_sense && io_fn == SK_READY && since_acc < SHIFT - 3 |=> !io_skip)
    else $error("ready during character shift");
  shift_out_a: assert property (io_out && !io_mask && since_acc < SHIFT - 3 |=> !io_skip)
    else $error("character taken during shift");
  busy_hold_a: assert property (io_sense && io_fn == SK_NOT_BUSY && since_en < ROW_POS |=> !io_skip)
    else $error("not busy right after enable");
  chan_take_a: assert property (chan_ack |-> chan_req)
    else $error("channel word without request");
  cover property (out_d ##0 io_skip);
  cover property (io_sense && io_fn == SK_NOT_BUSY ##1 io_skip);
  cover property (io_out && io_mask);
  cover property (chan_ack && chan_eor);
endmodule

// *** verif/card_punch_interface_tb.sv ***
/*
  Self-checking bench: both ends joined by the bus interface.
  Assumes shortened timing params; one row of channel words on a second card.
*/
`timescale 1ns/1ps
module card_punch_interface_tb;
  import cpi_pkg::*;
  localparam int P_ROW = 20;
  localparam int P_SH = 12;
  localparam int P_ADV = 40;
  localparam int P_TAIL = 30;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid, check_mode, readback_done, err_reset, rr_d, hole_sensed, word_valid, word_last;
  cpi_kind_type cmd_kind;
  logic [3:0] cmd_fn;
  logic [15:0] cmd_data, d, word_data;
  logic [7:0] not_ready, ch, sh;
  logic clutch_r, punch_bit_r, punch_clk_r, row_ready_r, check_err_r;
  logic cmd_ready_r, done_r, skip_r, irq_seen_r, word_taken_r;
  logic [7:0] exp_q[$];
  logic [7:0] got_q[$];
  int n_fail = 0, samples_checked = 0, cyc = 0, nclutch = 0, nrow = 0, nbits = 0;
  int seed, i, r, c, n, t0, ones;
  always #4 clock = ~clock;
  cpi_bus_if u_cpi_bus_if (.clk(clock), .rst(rst));
  cpi_punch_dev #(.ROW_POS(P_ROW), .SHIFT(P_SH), .ADVANCE(P_ADV), .TAIL(P_TAIL)) u_cpi_punch_dev (
    .bus(u_cpi_bus_if), .not_ready(not_ready), .check_mode(check_mode), .hole_sensed(hole_sensed),
    .readback_done(readback_done), .err_reset(err_reset), .clutch_r(clutch_r), .punch_bit_r(punch_bit_r),
    .punch_clk_r(punch_clk_r), .row_ready_r(row_ready_r), .check_err_r(check_err_r));
  cpi_cpu_end u_cpi_cpu_end (
    .bus(u_cpi_bus_if), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_fn(cmd_fn), .cmd_data(cmd_data),
    .word_valid(word_valid), .word_data(word_data), .word_last(word_last), .cmd_ready_r(cmd_ready_r),
    .done_r(done_r), .skip_r(skip_r), .word_taken_r(word_taken_r), .irq_seen_r(irq_seen_r));
  cpi_bus_sva #(.SHIFT(P_SH), .ROW_POS(P_ROW)) u_cpi_bus_sva (
    .clk(u_cpi_bus_if.clk), .rst(u_cpi_bus_if.rst), .io_ctl(u_cpi_bus_if.io_ctl),
    .io_sense(u_cpi_bus_if.io_sense), .io_out(u_cpi_bus_if.io_out), .io_mask(u_cpi_bus_if.io_mask),
    .io_fn(u_cpi_bus_if.io_fn), .io_data(u_cpi_bus_if.io_data), .io_skip(u_cpi_bus_if.io_skip),
    .irq(u_cpi_bus_if.irq), .chan_req(u_cpi_bus_if.chan_req), .chan_ack(u_cpi_bus_if.chan_ack),
    .chan_eor(u_cpi_bus_if.chan_eor));
  // Reads pre-edge register values, so no race with the design
  always @(posedge clock) begin
    cyc++;
    if (clutch_r === 1'b1) nclutch++;
    if (row_ready_r === 1'b1 && rr_d !== 1'b1) nrow++;
    rr_d = row_ready_r;
    if (punch_clk_r === 1'b1) begin
      sh = {sh[6:0], punch_bit_r};
      nbits++;
      if (nbits % 8 == 0) got_q.push_back(sh);
    end
  end
  task results;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk_bit(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask
  task chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task fail_to(input string nm);
    n_fail++;
    $display("mismatch %s expected change seen timeout", nm);
    results();
  endtask
  // Entered at a falling edge; returns at the falling edge showing done_r
  task cmd(input cpi_kind_type k, input logic [3:0] f, input logic [15:0] dv);
    int j;
    j = 0;
    while (cmd_ready_r !== 1'b1 && j < 20) begin
      @(negedge clock);
      j++;
    end
    if (j >= 20) fail_to("cmd_ready_r");
    cmd_kind = k;
    cmd_fn = f;
    cmd_data = dv;
    cmd_valid = 1'b1;
    @(negedge clock);
    cmd_valid = 1'b0;
    j = 0;
    while (done_r !== 1'b1 && j < 20) begin
      @(negedge clock);
      j++;
    end
    if (j >= 20) fail_to("done_r");
  endtask
  task poll(input logic [3:0] f, output int cycles);
    int j, s;
    s = cyc;
    for (j = 0; j < 60; j++) begin
      cmd(KIND_SENSE, f, 16'h0000);
      if (skip_r === 1'b1) break;
    end
    if (j >= 60) fail_to("sense skip");
    cycles = cyc - s;
  endtask
  initial begin
    seed = 88098;
    cmd_valid = 1'b0;
    cmd_kind = KIND_CTL;
    cmd_fn = 4'h0;
    cmd_data = 16'h0000;
    not_ready = 8'h00;
    check_mode = 1'b0;
    readback_done = 1'b0;
    err_reset = 1'b0;
    hole_sensed = 1'b0;
    word_valid = 1'b0;
    word_last = 1'b0;
    word_data = 16'h0000;
    repeat (10) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    for (i = 0; i <= 8; i++) begin
      not_ready = (i < 8) ? (8'h01 << i) : 8'h00;
      cmd(KIND_SENSE, SK_OPERATIONAL, 16'h0000);
      chk_bit("operational", i == 8, skip_r);
    end
    cmd(KIND_SENSE, SK_NOT_BUSY, 16'h0000);
    chk_bit("idle not busy", 1'b1, skip_r);
    $display("test sense done");
    check_mode = 1'b1;
    ones = 0;
    cmd(KIND_CTL, FN_ENABLE, 16'h0000);
    cmd(KIND_SENSE, SK_NOT_BUSY, 16'h0000);
    chk_bit("busy after enable", 1'b0, skip_r);
    for (r = 0; r < ROWS_PER_CARD; r++) begin
      poll(SK_READY, n);
      if (r == 0) begin
        chk_bit("first ready in time", 1'b1, n <= P_ROW + 16);
        d = $random(seed);
        d[MASK_BIT] = 1'b1;
        cmd(KIND_MASK, FN_DATA, d);
        chk_bit("mask no skip", 1'b0, skip_r);
        cmd(KIND_SENSE, SK_NOT_INTR, 16'h0000);
        chk_bit("interrupting", 1'b0, skip_r);
        chk_bit("irq seen", 1'b1, irq_seen_r);
        d[MASK_BIT] = 1'b0;
        cmd(KIND_MASK, FN_DATA, d);
        cmd(KIND_SENSE, SK_NOT_INTR, 16'h0000);
        chk_bit("not interrupting", 1'b1, skip_r);
        // Second enable lands while busy and must not clutch again
        cmd(KIND_CTL, FN_ENABLE, 16'h0000);
        chk_val("clutch count", 16'h0001, nclutch[15:0]);
      end else begin
        chk_bit("advance gap", 1'b1, n >= P_ADV - 4 && n <= P_ADV + P_SH + 20);
      end
      cmd(KIND_SENSE, SK_ROW_NOT_POS, 16'h0000);
      chk_bit("row positioned", 1'b0, skip_r);
      for (c = 0; c < CHARS_PER_ROW; c++) begin
        if (c > 0) poll(SK_READY, n);
        d = $random(seed);
        ch = (r == 0 && c == 0) ? 8'h80 : (r == 11 && c == 9) ? 8'h01 : d[7:0];
        d[7:0] = ch;
        cmd(KIND_OUT, FN_DATA, d);
        chk_bit("char accepted", 1'b1, skip_r);
        exp_q.push_back(ch);
        ones += $countones(ch);
        if (c == 0) begin
          cmd(KIND_OUT, FN_DATA, ~d);
          chk_bit("refused while shifting", 1'b0, skip_r);
        end
      end
    end
    $display("test card done");
    cmd(KIND_SENSE, SK_NOT_BUSY, 16'h0000);
    chk_bit("busy after last char", 1'b0, skip_r);
    poll(SK_NOT_BUSY, n);
    chk_bit("busy tail", 1'b1, n >= P_TAIL - 8 && n <= P_TAIL + P_SH + 20);
    chk_val("rows per card", 16'd12, nrow[15:0]);
    chk_val("bits per card", 16'd960, nbits[15:0]);
    for (i = 0; i < exp_q.size() && i < got_q.size(); i++) begin
      chk_val("serial char", {8'h00, exp_q[i]}, {8'h00, got_q[i]});
    end
    // Sensed holes first match the punched ones, then one extra hole must mismatch
    hole_sensed = 1'b1;
    repeat (ones) @(negedge clock);
    hole_sensed = 1'b0;
    readback_done = 1'b1;
    @(negedge clock);
    readback_done = 1'b0;
    repeat (3) @(negedge clock);
    chk_bit("punch check match", 1'b0, check_err_r);
    hole_sensed = 1'b1;
    @(negedge clock);
    hole_sensed = 1'b0;
    readback_done = 1'b1;
    @(negedge clock);
    readback_done = 1'b0;
    for (i = 0; i < 8 && check_err_r !== 1'b1; i++) @(negedge clock);
    chk_bit("punch check", 1'b1, check_err_r);
    err_reset = 1'b1;
    @(negedge clock);
    err_reset = 1'b0;
    repeat (3) @(negedge clock);
    chk_bit("error cleared", 1'b0, check_err_r);
    $display("test check done");
    // Second card: one row through the channel, end of range on its tenth word
    check_mode = 1'b0;
    cmd(KIND_CTL, FN_CHAN_MODE, 16'h0000);
    cmd(KIND_CTL, FN_ENABLE, 16'h0000);
    chk_val("clutch count", 16'h0002, nclutch[15:0]);
    t0 = exp_q.size();
    word_valid = 1'b1;
    word_data = $random(seed);
    for (c = 0; c < CHARS_PER_ROW; c++) begin
      word_last = (c == CHARS_PER_ROW - 1);
      for (i = 0; i < 200 && word_taken_r !== 1'b1; i++) @(negedge clock);
      if (i >= 200) fail_to("word_taken_r");
      exp_q.push_back(word_data[7:0]);
      word_data = $random(seed);
      @(negedge clock);
    end
    word_valid = 1'b0;
    word_last = 1'b0;
    // Tenth character is still shifting now, so only the channel stop can interrupt
    d = $random(seed);
    d[MASK_BIT] = 1'b1;
    cmd(KIND_MASK, FN_DATA, d);
    cmd(KIND_SENSE, SK_NOT_INTR, 16'h0000);
    chk_bit("channel stop irq", 1'b0, skip_r);
    cmd(KIND_CTL, FN_CHAN_STOP_CLR, 16'h0000);
    cmd(KIND_SENSE, SK_NOT_INTR, 16'h0000);
    chk_bit("channel stop cleared", 1'b1, skip_r);
    poll(SK_READY, n);
    d = $random(seed);
    cmd(KIND_OUT, FN_DATA, d);
    chk_bit("channel mode cleared", 1'b1, skip_r);
    exp_q.push_back(d[7:0]);
    repeat (P_SH) @(negedge clock);
    for (i = t0; i < exp_q.size(); i++) begin
      chk_val("channel char", {8'h00, exp_q[i]}, {8'h00, got_q[i]});
    end
    $display("test channel done");
    results();
  end
endmodule
